// >>> rtl/ssr_fifo.sv
// Purpose: small valid/ready FIFO for latched words
// Assumes: one clock, synchronous active-high reset
// Notes: full and empty come from an occupancy count
`default_nettype none
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // refused at elaboration: the pointers wrap by plain overflow
  if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_size
    $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic valid_q;
  logic [WIDTH-1:0] head_q;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign push = in_valid_i && in_ready_o && clk_en_i;
  assign pop = valid_q && out_ready_i && clk_en_i;
  assign rd_d = pop ? rd_q + 1'b1 : rd_q;
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      valid_q <= 1'b0;
    end else if (clk_en_i) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      valid_q <= (cnt_d != '0);
    end
  end
  // head word is registered so the outputs come straight from flops;
  // a word written into the slot that becomes the head bypasses the array
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      head_q <= (push && wr_q == rd_d) ? in_data_i : mem_q[rd_d];
    end
  end
  assign out_valid_o = valid_q;
  assign out_data_o = head_q;
  fifo_bound_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : ssr_fifo
`default_nettype wire

// >>> rtl/ssr_pkg.sv
// Purpose: constants for the serial shift and store register
// Assumes: one core clock; the shift clock arrives as a sampled input
// Notes: Functional notes below
//
// Functional notes
// - eight shift stages feed an eight-bit latch driven out through three-state drivers
// - on shift clock rise stage zero takes serial input, others shift along
// - latch follows stages while latch load high, holds while low
// - parallel outputs driven only while drive enable is high
// - enable low floats all parallel outputs; shifting and chain outputs keep working
// - rising edge moves stage six into seven; rise chain output shows it
// - falling edge copies last parallel stage into fall chain output
// - either chain output may feed the next device sharing the shift clock
`default_nettype none
package ssr_pkg;
  localparam int STAGES = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [STAGES-1:0] ZERO_WORD = 8'h00;
endpackage : ssr_pkg
`default_nettype wire

// >>> rtl/ssr_top.sv
// Purpose: serial-in parallel-out shift register with storage latch
// Assumes: shift clock, latch load and enables sampled on core_clk_i
// Notes: each latch load is also queued as a word through a FIFO while it has room
`default_nettype none
module ssr_top #(
  parameter int STAGES = ssr_pkg::STAGES,
  parameter int FIFO_DEPTH = ssr_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic serial_in_i,
  input wire logic shift_clock_i,
  input wire logic latch_load_i,
  input wire logic drive_en_i,
  output logic [STAGES-1:0] parallel_out_o,
  output logic [STAGES-1:0] parallel_out_oe_o,
  output logic chain_out_rise_o,
  output logic chain_out_fall_o,
  output logic word_valid_o,
  input wire logic word_ready_i,
  output logic [STAGES-1:0] word_data_o
);
  // ************************************************************
  // parameter checks
  // ************************************************************
  // refused at elaboration: stage numbering below assumes exactly eight
  if (STAGES != ssr_pkg::STAGES) begin : g_bad_stages
    $error("only eight stages supported");
  end
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("word queue needs at least two entries");
  end
  // ************************************************************
  // helper functions
  // ************************************************************
  localparam int FW = $clog2(STAGES) + 1;
  localparam logic [FW-1:0] FULL_COUNT = FW'(STAGES);
  // one detector serves both polarities so the two edges cannot drift apart
  function automatic logic level_edge(
    input logic now_lvl,
    input logic old_lvl,
    input logic pol
  );
    return (now_lvl == pol) && (old_lvl != pol);
  endfunction : level_edge
  // counts stop at a full register so they never wrap back to unknown data
  function automatic logic [FW-1:0] sat_inc(input logic [FW-1:0] cnt);
    return (cnt == FULL_COUNT) ? cnt : cnt + 1'b1;
  endfunction : sat_inc
  // ************************************************************
  // shift clock edge detection
  // ************************************************************
  // the shift clock is synchronous per assumption, so one history flop suffices
  logic sclk_q;
  logic rise;
  logic fall;
  logic rst_seen_q;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sclk_q <= 1'b0;
      rst_seen_q <= 1'b0;
    end else if (clk_en_i) begin
      sclk_q <= shift_clock_i;
      rst_seen_q <= 1'b1;
    end
  end
  // no edge is inferred on the first sample after reset
  assign rise = clk_en_i && rst_seen_q && level_edge(shift_clock_i, sclk_q, 1'b1);
  assign fall = clk_en_i && rst_seen_q && level_edge(shift_clock_i, sclk_q, 1'b0);
  // ************************************************************
  // shift stages and latch
  // ************************************************************
  // data state has no reset; it starts unknown like the real part
  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] latch_q;
  logic [STAGES-1:0] stage_d;
  logic rise_out_q;
  logic fall_out_q;
  assign stage_d = {stage_q[STAGES-2:0], serial_in_i};
  always_ff @(posedge core_clk_i) begin
    if (rise) begin
      stage_q <= stage_d;
      rise_out_q <= stage_q[STAGES-2];
    end
  end
  // the fall output trails by half a shift clock, giving the next device hold margin
  always_ff @(posedge core_clk_i) begin
    if (fall) begin
      fall_out_q <= stage_q[STAGES-1];
    end
  end
  // latch is transparent: it follows the stages including a same-cycle shift
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && latch_load_i) begin
      latch_q <= rise ? stage_d : stage_q;
    end
  end
  // ************************************************************
  // three-state drivers
  // ************************************************************
  // enable is registered so every output comes from a flop; it lags by one cycle
  logic [STAGES-1:0] oe_q;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      oe_q <= ssr_pkg::ZERO_WORD;
    end else if (clk_en_i) begin
      oe_q <= {STAGES{drive_en_i}};
    end
  end
  assign parallel_out_o = latch_q;
  assign parallel_out_oe_o = oe_q;
  assign chain_out_rise_o = rise_out_q;
  assign chain_out_fall_o = fall_out_q;
  // ************************************************************
  // word queue
  // ************************************************************
  // a word is queued when latch load falls, i.e. once per update
  logic load_q;
  logic push;
  logic fifo_ready;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      load_q <= 1'b0;
    end else if (clk_en_i) begin
      load_q <= latch_load_i;
    end
  end
  assign push = rst_seen_q && load_q && !latch_load_i;
  // a full queue drops the word; the latch itself never stalls
  ssr_fifo #(.WIDTH(STAGES), .DEPTH(FIFO_DEPTH)) ssr_fifo_inst (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(latch_q),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i),
    .out_data_o(word_data_o)
  );
  // ************************************************************
  // checker bookkeeping
  // ************************************************************
  // data state starts unknown, so the checks wait until it has been filled
  logic [FW-1:0] fill_q;
  logic [FW-1:0] seg_q;
  logic full;
  logic fall_known_q;
  logic latch_known_q;
  assign full = (fill_q == FULL_COUNT);
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fill_q <= '0;
    end else if (rise) begin
      fill_q <= sat_inc(fill_q);
    end
  end
  // rises since the last latch load, for the full word cover
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      seg_q <= '0;
    end else if (clk_en_i && latch_load_i) begin
      seg_q <= '0;
    end else if (rise) begin
      seg_q <= sat_inc(seg_q);
    end
  end
  // the fall output is only known after a fall that follows a full register
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fall_known_q <= 1'b0;
    end else if (fall && full) begin
      fall_known_q <= 1'b1;
    end
  end
  // the latch is only known once it has been loaded from a full register
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      latch_known_q <= 1'b0;
    end else if (clk_en_i && latch_load_i && full) begin
      latch_known_q <= 1'b1;
    end
  end
  // ************************************************************
  // checks
  // ************************************************************
  // checks on state that starts unknown wait for the flags above so power-up data never trips them
  shift_move_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rise && full) |=> stage_q == {$past(stage_q[STAGES-2:0]), $past(serial_in_i)})
    else $error("shift wrong");
  rise_out_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rise && full) |=> chain_out_rise_o == stage_q[STAGES-1]) else $error("rise out wrong");
  rise_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!rise && full) |=> $stable(chain_out_rise_o)) else $error("rise out moved");
  fall_out_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (fall && full) |=> chain_out_fall_o == $past(stage_q[STAGES-1])) else $error("fall wrong");
  fall_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!fall && fall_known_q) |=> $stable(chain_out_fall_o)) else $error("fall out moved");
  latch_follow_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i && latch_load_i && full) |=> parallel_out_o == stage_q) else $error("latch lag");
  latch_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!latch_load_i && latch_known_q) |=> $stable(parallel_out_o)) else $error("latch moved");
  drive_en_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i |=> parallel_out_oe_o == {STAGES{$past(drive_en_i)}}) else $error("oe wrong");
  float_shift_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rise && !drive_en_i) |=> stage_q[0] == $past(serial_in_i)) else $error("no shift");
  float_chain_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (fall && full && !drive_en_i) |=> chain_out_fall_o == $past(stage_q[STAGES-1]))
    else $error("no chain out");
  word_push_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i && push) |=> word_valid_o) else $error("word lost");
  // ************************************************************
  // cover points
  // ************************************************************
  full_word_c: cover property (@(posedge core_clk_i)
    clk_en_i && latch_load_i && seg_q == FULL_COUNT);
  float_c: cover property (@(posedge core_clk_i) rise && !drive_en_i);
  fall_edge_c: cover property (@(posedge core_clk_i) fall && fall_known_q);
  word_out_c: cover property (@(posedge core_clk_i) word_valid_o && word_ready_i);
  word_drop_c: cover property (@(posedge core_clk_i) clk_en_i && push && !fifo_ready);
endmodule : ssr_top
`default_nettype wire

// >>> tb/ssr_host.sv
// Purpose: host model that shifts bytes in and strobes the latch
// Assumes: drives its lines on the falling edge of core_clk_i
// Notes: serial line shows inverted data once the last bit is no longer sampled
`default_nettype none
module ssr_host (
  input wire logic core_clk_i,
  output logic serial_o,
  output logic shift_clock_o,
  output logic latch_load_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serial_o = 1'b0;
    shift_clock_o = 1'b0;
    latch_load_o = 1'b0;
  end
  // ************ transfer ************
  // msb first so it ends in the top stage; strobe only after shifting
  task automatic send(input logic [7:0] b, input logic ld);
    for (int k = 7; k >= 0; k--) begin
      @(negedge core_clk_i);
      shift_clock_o = 1'b0;
      serial_o = b[k];
      @(negedge core_clk_i);
      shift_clock_o = 1'b1;
    end
    @(negedge core_clk_i);
    serial_o = ~b[0];
    latch_load_o = ld;
    @(negedge core_clk_i);
    latch_load_o = 1'b0;
    shift_clock_o = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask : send
endmodule : ssr_host
`default_nettype wire

// >>> tb/test_serial_shift_store_register.sv
// Purpose: random and corner bytes through shifter, latch and word queue
// Assumes: inputs change on the falling edge; clock enable tied high
// Notes: ten strobed bytes overfill the eight-word queue on purpose
`default_nettype none
module test_serial_shift_store_register;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic drive_en_i = 1'b1;
  logic word_ready_i = 1'b0;
  logic ser, sclk, ld, rise_o, fall_o, wvalid;
  logic [7:0] par, oe, wdata, b, last;
  logic [31:0] seed = 32'h0000_0053;
  logic [7:0] q[$];
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  always #5 core_clk_i = ~core_clk_i;
  ssr_top ssr_top_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .serial_in_i(ser), .shift_clock_i(sclk), .latch_load_i(ld), .drive_en_i(drive_en_i),
    .parallel_out_o(par), .parallel_out_oe_o(oe), .chain_out_rise_o(rise_o),
    .chain_out_fall_o(fall_o), .word_valid_o(wvalid), .word_ready_i(word_ready_i),
    .word_data_o(wdata));
  ssr_host ssr_host_inst (.core_clk_i(core_clk_i), .serial_o(ser), .shift_clock_o(sclk),
    .latch_load_o(ld));
  // ************ helpers ************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xorshift
  // the first bit sent ends in the top stage, so both chain outputs show it
  function automatic logic [7:0] exp_chain(input logic [7:0] w);
    return {7'h00, w[7]};
  endfunction : exp_chain
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end
  // ************ sequence ************
  initial begin
    repeat (16) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 10; i++) begin
      seed = xorshift(seed);
      b = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : seed[7:0];
      if (i < 8) q.push_back(b);
      ssr_host_inst.send(b, 1'b1);
      chk(par, b);
      chk(oe, 8'hFF);
      chk({7'h00, rise_o}, exp_chain(b));
      chk({7'h00, fall_o}, exp_chain(b));
    end
    last = b;
    b = ~last;
    drive_en_i = 1'b0;
    ssr_host_inst.send(b, 1'b0);
    chk(oe, 8'h00);
    chk(par, last);
    chk({7'h00, rise_o}, exp_chain(b));
    chk({7'h00, fall_o}, exp_chain(b));
    // full queue dropped the last two words; oldest must come out first
    for (int i = 0; i < 8; i++) begin
      chk({7'h00, wvalid}, 8'h01);
      chk(wdata, q[i]);
      word_ready_i = 1'b1;
      @(negedge core_clk_i);
      word_ready_i = 1'b0;
      @(negedge core_clk_i);
    end
    chk({7'h00, wvalid}, 8'h00);
    stop_test();
  end
endmodule : test_serial_shift_store_register
`default_nettype wire
